// ==== rtl/nie_pend_bank.sv ====
/*
 * Request-pending flags of the maskable sources.
 * Assumes set and clear vectors come from logic on the same clock.
 */
`timescale 1ns/1ps
module nie_pend_bank (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [nie_pkg::NUM_SRC-1:0] set_vec,
   input wire logic [nie_pkg::NUM_SRC-1:0] clr_vec,
   output logic [nie_pkg::NUM_SRC-1:0] pend
);

   typedef struct packed {
      logic [nie_pkg::NUM_SRC-1:0] pend;
   } nie_pend_t;

   nie_pend_t s_ff;
   nie_pend_t nxt_s;

   // a request landing on its own acknowledge cycle is kept
   always_comb begin
      nxt_s = s_ff;
      nxt_s.pend = (s_ff.pend & ~clr_vec) | set_vec;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign pend = s_ff.pend;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   pend_clear_a: assert property (clr_vec != '0 && (clr_vec & set_vec) == '0 |=> (pend & $past(clr_vec)) == '0)
      else $error("pending flag not cleared on acknowledge");
   pend_hold_a: assert property (set_vec != '0 |=> (pend & $past(set_vec)) == $past(set_vec))
      else $error("new request lost");

endmodule // nie_pend_bank

// ==== rtl/nie_pkg.sv ====
/*
 * Shared constants for the interrupt entry block: register offsets, status word
 * layout, reset values, entry codes and priority helpers.
 * Assumes a single 40 MHz core clock and 32-bit register data.
 */
package nie_pkg;

   localparam int NUM_SRC = 42;
   localparam int LVL_W = 3;
   localparam int ADDR_W = 12;

   // status word layout and reset value
   localparam logic [31:0] PSW_RST = 32'h00000020;
   localparam int PSW_ID = 5;
   localparam int PSW_EP = 6;
   localparam int PSW_NP = 7;

   // watchdog mode bit pair
   localparam logic [1:0] WDM_RST = 2'h0;
   localparam logic [1:0] WDM_NMI = 2'h1;

   // non-maskable entry
   localparam logic [15:0] NMI_CODE = 16'h0010;
   localparam logic [31:0] NMI_HANDLER = 32'h00000010;

   // per-source control byte
   localparam logic [7:0] SRC_CTRL_RST = 8'h47;
   localparam int CTL_PEND = 7;
   localparam int CTL_MASK = 6;
   localparam logic [LVL_W-1:0] LVL_RST = 3'h7;
   localparam logic [3:0] LVL_NONE = 4'h8;

   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_CTRL_END = 12'h0A8;
   localparam logic [ADDR_W-1:0] OFS_PSW = 12'h100;
   localparam logic [ADDR_W-1:0] OFS_IPC = 12'h104;
   localparam logic [ADDR_W-1:0] OFS_IPSW = 12'h108;
   localparam logic [ADDR_W-1:0] OFS_NPC = 12'h10C;
   localparam logic [ADDR_W-1:0] OFS_NPSW = 12'h110;
   localparam logic [ADDR_W-1:0] OFS_CAUSE = 12'h114;
   localparam logic [ADDR_W-1:0] OFS_ISL = 12'h118;
   localparam logic [ADDR_W-1:0] OFS_WDM = 12'h11C;

   // entry code table: runs of consecutive codes, step 10H, gaps unused
   localparam logic [15:0] CODE_STEP = 16'h0010;
   localparam logic [5:0] SEG2_FIRST = 6'h08;
   localparam logic [5:0] SEG3_FIRST = 6'h12;
   localparam logic [5:0] SEG4_FIRST = 6'h1E;
   localparam logic [5:0] SEG5_FIRST = 6'h27;
   localparam logic [5:0] SEG6_FIRST = 6'h29;
   localparam logic [15:0] SEG1_BASE = 16'h0080;
   localparam logic [15:0] SEG2_BASE = 16'h0120;
   localparam logic [15:0] SEG3_BASE = 16'h0240;
   localparam logic [15:0] SEG4_BASE = 16'h0340;
   localparam logic [15:0] SEG5_BASE = 16'h0400;
   localparam logic [15:0] SEG6_BASE = 16'h0430;

   // entry code of a source, by default priority index; handler address equals it
   function automatic logic [15:0] src_code(input logic [5:0] idx);
      logic [5:0] first;
      logic [15:0] base;
      logic [5:0] off;
      first = 6'h00;
      base = SEG1_BASE;
      if (idx >= SEG6_FIRST) begin
         first = SEG6_FIRST;
         base = SEG6_BASE;
      end else if (idx >= SEG5_FIRST) begin
         first = SEG5_FIRST;
         base = SEG5_BASE;
      end else if (idx >= SEG4_FIRST) begin
         first = SEG4_FIRST;
         base = SEG4_BASE;
      end else if (idx >= SEG3_FIRST) begin
         first = SEG3_FIRST;
         base = SEG3_BASE;
      end else if (idx >= SEG2_FIRST) begin
         first = SEG2_FIRST;
         base = SEG2_BASE;
      end
      off = idx - first;
      src_code = base + CODE_STEP * {10'h000, off};
   endfunction

   // level now in service: lowest set bit, LVL_NONE when idle
   function automatic logic [3:0] cur_level(input logic [7:0] isl);
      cur_level = LVL_NONE;
      for (int i = 7; i >= 0; i--) begin
         if (isl[i]) begin
            cur_level = 4'(i);
         end
      end
   endfunction

endpackage

// ==== rtl/nie_prio_arb.sv ====
/*
 * Picks the winning unmasked pending source: lowest level number first,
 * lowest default priority index on a tie.
 * Purely combinational; assumes levels packed three bits per source.
 */
`timescale 1ns/1ps
module nie_prio_arb (
   input wire logic [nie_pkg::NUM_SRC-1:0] pend,
   input wire logic [nie_pkg::NUM_SRC-1:0] msk,
   input wire logic [nie_pkg::NUM_SRC*nie_pkg::LVL_W-1:0] lvl,
   output logic win_vld,
   output logic [5:0] win_idx,
   output logic [nie_pkg::LVL_W-1:0] win_lvl
);

   // strict less keeps the earlier index on equal levels
   always_comb begin
      win_vld = 1'b0;
      win_idx = 6'h00;
      win_lvl = nie_pkg::LVL_RST;
      for (int i = 0; i < nie_pkg::NUM_SRC; i++) begin
         if (pend[i] && !msk[i]) begin
            if (!win_vld || lvl[i*nie_pkg::LVL_W +: nie_pkg::LVL_W] < win_lvl) begin
               win_vld = 1'b1;
               win_idx = 6'(i);
               win_lvl = lvl[i*nie_pkg::LVL_W +: nie_pkg::LVL_W];
            end
         end
      end
   end

endmodule // nie_prio_arb

// ==== rtl/nie_top.sv ====
/*
 * Interrupt acknowledge and return unit: one watchdog non-maskable source,
 * 42 maskable sources with eight programmable levels, saved PC and status
 * registers, cause register, in-service levels and the CPU status word.
 * Assumes requests, instruction strobes and the next PC come from logic on
 * CORE_CLK; the pipeline redirects fetch when PC_LOAD pulses.
 */
// The implementer's own choices: strobed register access and the placing of the registers.
// Summary of operation
// - nmi taken despite disable, beats all others
// - nmi source is watchdog overflow, mode 01
// - nmi saves pc and status, cause 0010H
// - nmi sets np and id, clears ep
// - return with ep0 np1 restores nmi pair
// - nmi in service blocks every acceptance
// - status word resets to 00000020H
// - 42 maskable sources, each maskable
// - simultaneous requests follow default priority
// - eight programmable levels arbitrate requests
// - equal levels resolved by default priority
// - acknowledge sets the interrupt disable flag
// - nesting only for strictly higher level
// - irq saves pc and status, source cause
// - irq sets id, clears ep, loads handler
// - masked or blocked requests stay pending
// - return with ep0 np0 restores irq pair
// - in-service level bit set until return
// - acknowledge clears source pending flag
// - level 0 highest through 7 lowest
// - default priority 0 is highest
`timescale 1ns/1ps
module nie_top (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic [nie_pkg::ADDR_W-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [31:0] RDATA,
   input wire logic [nie_pkg::NUM_SRC-1:0] IRQ_REQ,
   input wire logic WDT_OVF,
   input wire logic [31:0] CPU_NEXT_PC,
   input wire logic RETURN_FROM_INTERRUPT_STB,
   input wire logic EI_STB,
   input wire logic DI_STB,
   output logic PC_LOAD,
   output logic [31:0] PC_TARGET,
   output logic [31:0] STATUS_WORD
);

   typedef struct packed {
      logic [31:0] cpu_status_word;
      logic [31:0] ipc;
      logic [31:0] ipsw;
      logic [31:0] npc;
      logic [31:0] npsw;
      logic [31:0] cause;
      logic [31:0] tgt;
      logic [31:0] rdat;
      logic [7:0] isl;
      logic [1:0] wdm;
      logic nmi_pend;
      logic load;
      logic [nie_pkg::NUM_SRC-1:0] msk;
      logic [nie_pkg::NUM_SRC*nie_pkg::LVL_W-1:0] lvl;
   } nie_state_t;

   nie_state_t s_ff;
   nie_state_t nxt_s;

   logic [nie_pkg::NUM_SRC-1:0] pend;
   logic [nie_pkg::NUM_SRC-1:0] sw_set;
   logic [nie_pkg::NUM_SRC-1:0] sw_clr;
   logic [nie_pkg::NUM_SRC-1:0] ack_vec;
   logic win_vld;
   logic [5:0] win_idx;
   logic [nie_pkg::LVL_W-1:0] win_lvl;
   logic [3:0] cur_lvl;
   logic ctrl_hit;
   logic [5:0] ctrl_idx;
   logic np;
   logic id;
   logic ep;
   logic nmi_take;
   logic irq_take;
   logic return_from_interrupt_nmi;
   logic return_from_interrupt_irq;
   logic wdt_nmi;

   ////////////////////////////////////////////////////////////////////////////////
   // decode and acceptance

   assign np = s_ff.cpu_status_word[nie_pkg::PSW_NP];
   assign id = s_ff.cpu_status_word[nie_pkg::PSW_ID];
   assign ep = s_ff.cpu_status_word[nie_pkg::PSW_EP];
   assign cur_lvl = nie_pkg::cur_level(s_ff.isl);
   assign ctrl_hit = ADDR < nie_pkg::OFS_CTRL_END && ADDR[1:0] == 2'h0;
   assign ctrl_idx = ADDR[7:2];

   assign wdt_nmi = WDT_OVF && s_ff.wdm == nie_pkg::WDM_NMI;
   // a return in flight redirects fetch itself, so entry waits a cycle
   assign return_from_interrupt_nmi = RETURN_FROM_INTERRUPT_STB && !ep && np;
   assign return_from_interrupt_irq = RETURN_FROM_INTERRUPT_STB && !ep && !np;
   assign nmi_take = s_ff.nmi_pend && !np && !RETURN_FROM_INTERRUPT_STB;
   assign irq_take = win_vld && !np && !id && !nmi_take && !RETURN_FROM_INTERRUPT_STB
      && {1'b0, win_lvl} < cur_lvl;

   assign ack_vec = irq_take ? (42'h1 << win_idx) : '0;
   assign sw_set = (WR_STB && ctrl_hit && WDATA[nie_pkg::CTL_PEND]) ? (42'h1 << ctrl_idx) : '0;
   assign sw_clr = (WR_STB && ctrl_hit && !WDATA[nie_pkg::CTL_PEND]) ? (42'h1 << ctrl_idx) : '0;

   nie_pend_bank u_pend (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .set_vec(IRQ_REQ | sw_set),
      .clr_vec(ack_vec | sw_clr),
      .pend(pend)
   );

   nie_prio_arb u_arb (
      .pend(pend),
      .msk(s_ff.msk),
      .lvl(s_ff.lvl),
      .win_vld(win_vld),
      .win_idx(win_idx),
      .win_lvl(win_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state: bus access, then instruction strobes, then return and entry

   always_comb begin
      nxt_s = s_ff;
      nxt_s.load = 1'b0;
      nxt_s.rdat = 32'h00000000;
      if (WR_STB) begin
         if (ctrl_hit) begin
            nxt_s.msk[ctrl_idx] = WDATA[nie_pkg::CTL_MASK];
            nxt_s.lvl[3*ctrl_idx +: 3] = WDATA[2:0];
         end
         case (ADDR)
            nie_pkg::OFS_PSW: nxt_s.cpu_status_word = WDATA;
            nie_pkg::OFS_IPC: nxt_s.ipc = WDATA;
            nie_pkg::OFS_IPSW: nxt_s.ipsw = WDATA;
            nie_pkg::OFS_NPC: nxt_s.npc = WDATA;
            nie_pkg::OFS_NPSW: nxt_s.npsw = WDATA;
            nie_pkg::OFS_WDM: nxt_s.wdm = WDATA[1:0];
            default: ;
         endcase
      end
      if (RD_STB) begin
         if (ctrl_hit) begin
            nxt_s.rdat = {24'h000000, pend[ctrl_idx], s_ff.msk[ctrl_idx], 3'h0,
               s_ff.lvl[3*ctrl_idx +: 3]};
         end
         case (ADDR)
            nie_pkg::OFS_PSW: nxt_s.rdat = s_ff.cpu_status_word;
            nie_pkg::OFS_IPC: nxt_s.rdat = s_ff.ipc;
            nie_pkg::OFS_IPSW: nxt_s.rdat = s_ff.ipsw;
            nie_pkg::OFS_NPC: nxt_s.rdat = s_ff.npc;
            nie_pkg::OFS_NPSW: nxt_s.rdat = s_ff.npsw;
            nie_pkg::OFS_CAUSE: nxt_s.rdat = s_ff.cause;
            nie_pkg::OFS_ISL: nxt_s.rdat = {24'h000000, s_ff.isl};
            nie_pkg::OFS_WDM: nxt_s.rdat = {30'h00000000, s_ff.wdm};
            default: ;
         endcase
      end
      if (EI_STB) begin
         nxt_s.cpu_status_word[nie_pkg::PSW_ID] = 1'b0;
      end
      if (DI_STB) begin
         nxt_s.cpu_status_word[nie_pkg::PSW_ID] = 1'b1;
      end
      if (return_from_interrupt_nmi) begin
         nxt_s.cpu_status_word = s_ff.npsw;
         nxt_s.tgt = s_ff.npc;
         nxt_s.load = 1'b1;
      end else if (return_from_interrupt_irq) begin
         nxt_s.cpu_status_word = s_ff.ipsw;
         nxt_s.tgt = s_ff.ipc;
         nxt_s.load = 1'b1;
         if (cur_lvl != nie_pkg::LVL_NONE) begin
            nxt_s.isl[cur_lvl[2:0]] = 1'b0;
         end
      end else if (RETURN_FROM_INTERRUPT_STB) begin
         // exception return: no level was granted, so none is retired
         nxt_s.cpu_status_word = s_ff.ipsw;
         nxt_s.tgt = s_ff.ipc;
         nxt_s.load = 1'b1;
      end else if (nmi_take) begin
         nxt_s.npc = CPU_NEXT_PC;
         nxt_s.npsw = s_ff.cpu_status_word;
         nxt_s.cause[31:16] = nie_pkg::NMI_CODE;
         nxt_s.cpu_status_word[nie_pkg::PSW_NP] = 1'b1;
         nxt_s.cpu_status_word[nie_pkg::PSW_ID] = 1'b1;
         nxt_s.cpu_status_word[nie_pkg::PSW_EP] = 1'b0;
         nxt_s.tgt = nie_pkg::NMI_HANDLER;
         nxt_s.load = 1'b1;
      end else if (irq_take) begin
         nxt_s.ipc = CPU_NEXT_PC;
         nxt_s.ipsw = s_ff.cpu_status_word;
         nxt_s.cause[15:0] = nie_pkg::src_code(win_idx);
         nxt_s.cpu_status_word[nie_pkg::PSW_ID] = 1'b1;
         nxt_s.cpu_status_word[nie_pkg::PSW_EP] = 1'b0;
         nxt_s.tgt = {16'h0000, nie_pkg::src_code(win_idx)};
         nxt_s.isl[win_lvl] = 1'b1;
         nxt_s.load = 1'b1;
      end
      if (nmi_take) begin
         nxt_s.nmi_pend = 1'b0;
      end
      if (wdt_nmi) begin
         nxt_s.nmi_pend = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         s_ff <= '0;
         s_ff.cpu_status_word <= nie_pkg::PSW_RST;
         s_ff.wdm <= nie_pkg::WDM_RST;
         s_ff.msk <= '1;
         s_ff.lvl <= {nie_pkg::NUM_SRC{nie_pkg::LVL_RST}};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign RDATA = s_ff.rdat;
   assign PC_LOAD = s_ff.load;
   assign PC_TARGET = s_ff.tgt;
   assign STATUS_WORD = s_ff.cpu_status_word;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);

   nmi_entry_a: assert property (nmi_take && id |=> PC_LOAD && PC_TARGET == nie_pkg::NMI_HANDLER)
      else $error("nmi not taken while disabled");
   nmi_first_a: assert property (nmi_take |-> !irq_take)
      else $error("maskable entry beat nmi");
   wdt_mode_a: assert property (WDT_OVF && s_ff.wdm != nie_pkg::WDM_NMI && !s_ff.nmi_pend
      |=> !s_ff.nmi_pend)
      else $error("nmi raised outside nmi mode");
   nmi_save_a: assert property (nmi_take |=> s_ff.npc == $past(CPU_NEXT_PC)
      && s_ff.npsw == $past(s_ff.cpu_status_word) && s_ff.cause[31:16] == nie_pkg::NMI_CODE)
      else $error("nmi save or cause wrong");
   nmi_flags_a: assert property (nmi_take |=> np && id && !ep)
      else $error("nmi status flags wrong");
   nmi_ret_a: assert property (return_from_interrupt_nmi |=> PC_LOAD && PC_TARGET == $past(s_ff.npc)
      && STATUS_WORD == $past(s_ff.npsw))
      else $error("nmi return restored wrong pair");
   np_block_a: assert property (np |-> !irq_take && !nmi_take)
      else $error("entry accepted during nmi service");
   irq_disable_a: assert property (irq_take |=> id && !ep && PC_LOAD)
      else $error("maskable entry left interrupts enabled");
   nest_level_a: assert property (irq_take |-> {1'b0, win_lvl} < cur_lvl)
      else $error("nested entry at equal or lower level");
   irq_save_a: assert property (irq_take |=> s_ff.ipc == $past(CPU_NEXT_PC)
      && s_ff.cause[15:0] == PC_TARGET[15:0] && s_ff.isl[$past(win_lvl)])
      else $error("maskable save or cause wrong");
   irq_ret_a: assert property (return_from_interrupt_irq && cur_lvl != nie_pkg::LVL_NONE
      |=> PC_TARGET == $past(s_ff.ipc) && !s_ff.isl[$past(cur_lvl[2:0])])
      else $error("maskable return wrong");

   nmi_entry_c: cover property (nmi_take ##1 PC_LOAD);
   irq_entry_c: cover property (irq_take ##[1:20] return_from_interrupt_irq);
   nested_c: cover property (irq_take && cur_lvl != nie_pkg::LVL_NONE);
   nmi_ret_c: cover property (return_from_interrupt_nmi);

endmodule // nie_top

// ==== test/nie_cpu_model.sv ====
/*
 * Behavioural CPU pipeline facing the interrupt unit: return address and
 * the return, enable and disable instruction strobes.
 * Assumes the core clock of the unit; the pipeline is stalled, so the
 * return address only moves on a redirect or when the bench places it.
 */
`timescale 1ns/1ps
module nie_cpu_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pc_load,
   input wire logic [31:0] pc_target,
   output logic [31:0] next_pc,
   output logic return_from_interrupt_stb,
   output logic ei_stb,
   output logic di_stb
);
   initial begin
      return_from_interrupt_stb = 1'b0;
      ei_stb = 1'b0;
      di_stb = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         next_pc <= 32'h00002000;
      end else if (pc_load) begin
         next_pc <= pc_target;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // two edges of slack so a redirect still landing cannot race the new value
   task automatic set_pc(input logic [31:0] v);
      repeat (2) @(posedge clk);
      next_pc <= v;
   endtask
   // k: 0 return, 1 enable, 2 disable; lag models a slow pipeline
   task automatic instr(input int k, input int lag);
      repeat (lag) @(posedge clk);
      @(posedge clk);
      return_from_interrupt_stb <= (k == 0);
      ei_stb <= (k == 1);
      di_stb <= (k == 2);
      @(posedge clk);
      return_from_interrupt_stb <= 1'b0;
      ei_stb <= 1'b0;
      di_stb <= 1'b0;
   endtask
endmodule // nie_cpu_model

// ==== test/nie_top_test.sv ====
/*
 * Self-checking bench of the interrupt entry unit: register port tasks,
 * request pulses and instruction strobes from the CPU model.
 * Assumes nie_pkg, the design files and nie_cpu_model compiled first.
 */
`timescale 1ns/1ps
module nie_top_test;
   localparam logic [31:0] ANY = 32'hFFFFFFFF;
   logic CORE_CLK, RSTN, WR_STB, RD_STB, WDT_OVF, PC_LOAD;
   logic RETURN_FROM_INTERRUPT_STB, EI_STB, DI_STB;
   logic [nie_pkg::ADDR_W-1:0] ADDR;
   logic [31:0] WDATA, RDATA, CPU_NEXT_PC, PC_TARGET, STATUS_WORD, d, sv_pc, sv_st;
   logic [nie_pkg::NUM_SRC-1:0] IRQ_REQ;
   int miscompares = 0;
   int comparisons = 0;

   initial begin
      CORE_CLK = 1'b0;
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end

   nie_top DUT (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
      .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .IRQ_REQ(IRQ_REQ),
      .WDT_OVF(WDT_OVF), .CPU_NEXT_PC(CPU_NEXT_PC), .RETURN_FROM_INTERRUPT_STB(RETURN_FROM_INTERRUPT_STB),
      .EI_STB(EI_STB), .DI_STB(DI_STB), .PC_LOAD(PC_LOAD), .PC_TARGET(PC_TARGET),
      .STATUS_WORD(STATUS_WORD));
   nie_cpu_model cpu (.clk(CORE_CLK), .rst_n(RSTN), .pc_load(PC_LOAD),
      .pc_target(PC_TARGET), .next_pc(CPU_NEXT_PC), .return_from_interrupt_stb(RETURN_FROM_INTERRUPT_STB),
      .ei_stb(EI_STB), .di_stb(DI_STB));
   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge CORE_CLK);
      ADDR <= a;
      WDATA <= v;
      WR_STB <= 1'b1;
      @(posedge CORE_CLK);
      WR_STB <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a);
      @(posedge CORE_CLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge CORE_CLK);
      RD_STB <= 1'b0;
      #1;
      d = RDATA;
   endtask
   task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp,
      input logic [31:0] msk = 32'hFFFFFFFF);
      rd(a);
      chk(what, exp, d & msk);
   endtask
   task automatic pulse(input logic [nie_pkg::NUM_SRC-1:0] v, input logic w);
      @(posedge CORE_CLK);
      IRQ_REQ <= v;
      WDT_OVF <= w;
      @(posedge CORE_CLK);
      IRQ_REQ <= '0;
      WDT_OVF <= 1'b0;
   endtask
   // a redirect may already stand right after the edge that ended the last call
   task automatic wait_load(input logic [31:0] exp);
      #1;
      for (int n = 0; n < 8 && PC_LOAD !== 1'b1; n++) begin
         @(posedge CORE_CLK);
         #1;
      end
      chk("redirect", 32'h1, 32'(PC_LOAD));
      if (exp !== ANY) chk("target", exp, PC_TARGET);
      // step past this pulse so a following call sees only the next one
      @(posedge CORE_CLK);
   endtask
   task automatic no_load(input int n);
      repeat (n) begin
         @(posedge CORE_CLK);
         #1;
         chk("no redirect", 32'h0, 32'(PC_LOAD));
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #(25 * 4000);
      miscompares++;
      final_report;
   end

   initial begin
      RSTN = 1'b0;
      ADDR = '0;
      WDATA = '0;
      WR_STB = 1'b0;
      RD_STB = 1'b0;
      IRQ_REQ = '0;
      WDT_OVF = 1'b0;
      repeat (20) @(posedge CORE_CLK);
      RSTN <= 1'b1;
      #1;
      chk("status", nie_pkg::PSW_RST, STATUS_WORD);
      rdc("ctrl0", 12'h000, 32'h47);
      rdc("ctrl41", 12'h0A4, 32'h47);
      rdc("unmapped", 12'h200, 32'h0);
      rdc("in_svc", 12'h118, 32'h0);
      // single entry, then an equal level held off with nesting enabled
      cpu.instr(1, 0);
      #1;
      chk("status", 32'h0, STATUS_WORD);
      wr(12'h020, 32'h0);
      wr(12'h000, 32'h0);
      pulse(42'h1 << 8, 1'b0);
      wait_load(32'h120);
      chk("status", 32'h20, STATUS_WORD);
      rdc("cause", 12'h114, 32'h120, 32'h0000FFFF);
      rdc("ipc", 12'h104, 32'h2000);
      rdc("ipsw", 12'h108, 32'h0);
      rdc("in_svc", 12'h118, 32'h1);
      rdc("pend8", 12'h020, 32'h0);
      cpu.instr(1, 2);
      pulse(42'h1, 1'b0);
      no_load(6);
      rdc("pend0", 12'h000, 32'h80);
      cpu.instr(2, 0);
      wr(12'h104, 32'h2000);
      wr(12'h108, 32'h0);
      cpu.instr(0, 1);
      wait_load(32'h2000);
      wait_load(32'h80);
      rdc("in_svc", 12'h118, 32'h1);
      cpu.instr(0, 0);
      wait_load(ANY);
      rdc("in_svc", 12'h118, 32'h0);
      // three at once over two levels, then a strictly higher level nests
      wr(12'h014, 32'h2);
      wr(12'h050, 32'h1);
      wr(12'h078, 32'h1);
      wr(12'h0A4, 32'h0);
      pulse((42'h1 << 5) | (42'h1 << 20) | (42'h1 << 30), 1'b0);
      wait_load(32'h260);
      rd(12'h104);
      sv_pc = d;
      rd(12'h108);
      sv_st = d;
      cpu.instr(1, 0);
      pulse(42'h1 << 41, 1'b0);
      wait_load(32'h430);
      rdc("in_svc", 12'h118, 32'h3);
      cpu.instr(0, 0);
      wait_load(32'h260);
      rdc("in_svc", 12'h118, 32'h2);
      no_load(4);
      cpu.instr(2, 0);
      wr(12'h104, sv_pc);
      wr(12'h108, sv_st);
      cpu.instr(0, 3);
      wait_load(sv_pc);
      wait_load(32'h340);
      cpu.instr(0, 0);
      wait_load(ANY);
      wait_load(32'h0D0);
      cpu.instr(0, 0);
      wait_load(ANY);
      // overflow only counts in mode 01
      cpu.set_pc(32'h3000);
      for (int m = 0; m < 4; m++) begin
         if (m != 1) begin
            wr(12'h11C, 32'(m));
            pulse('0, 1'b1);
            no_load(4);
         end
      end
      wr(12'h11C, 32'h1);
      pulse(42'h1, 1'b1);
      wait_load(nie_pkg::NMI_HANDLER);
      chk("status", 32'hA0, STATUS_WORD);
      rdc("npc", 12'h10C, 32'h3000);
      rdc("npsw", 12'h110, 32'h0);
      rdc("cause", 12'h114, 32'h00100000, 32'hFFFF0000);
      cpu.instr(1, 0);
      no_load(6);
      rdc("pend0", 12'h000, 32'h80);
      cpu.instr(0, 0);
      wait_load(32'h3000);
      chk("status", 32'h0, STATUS_WORD);
      wait_load(32'h80);
      cpu.instr(0, 0);
      wait_load(ANY);
      final_report;
   end
endmodule // nie_top_test
